// file: core/relay_node_pkg.sv
// package: register map, reset defaults and configuration limits of the switching node bank
package relay_node_pkg;

  localparam int AddrW = 8;
  localparam int DataW = 16;

  // holding registers
  localparam logic [7:0] OffOverVoltageLimit = 8'h00;
  localparam logic [7:0] OffUnderVoltageLimit = 8'h04;
  localparam logic [7:0] OffOverCurrentLimit = 8'h08;
  localparam logic [7:0] OffUnderCurrentLimit = 8'h0c;
  localparam logic [7:0] OffOverFrequencyLimit = 8'h10;
  localparam logic [7:0] OffUnderFrequencyLimit = 8'h14;
  localparam logic [7:0] OffOverTempPrewarning = 8'h18;
  localparam logic [7:0] OffHoldCurrentPeriod = 8'h1c;
  localparam logic [7:0] OffLoadHoursPreset = 8'h20;
  localparam logic [7:0] OffLoadDevVoltageRef = 8'h24;
  localparam logic [7:0] OffLoadDevCurrentRef = 8'h28;
  localparam logic [7:0] OffLoadDevPercentage = 8'h2c;
  localparam logic [7:0] OffOutputSubstituteMode = 8'h30;
  localparam logic [7:0] OffOutputSubstituteValue = 8'h34;
  localparam logic [7:0] OffFiringSetup = 8'h38;
  localparam logic [7:0] OffTimeBaseSetting = 8'h3c;
  localparam logic [7:0] OffControlLevel = 8'h40;
  localparam logic [7:0] OffOnOffControlZero = 8'h44;
  localparam logic [7:0] OffOnOffControlOne = 8'h48;
  // input registers
  localparam logic [7:0] OffHoldCurrentReading = 8'h80;
  localparam logic [7:0] OffRmsVoltageReading = 8'h84;
  localparam logic [7:0] OffLineFrequencyReading = 8'h88;
  localparam logic [7:0] OffRmsCurrentReading = 8'h8c;
  localparam logic [7:0] OffApparentPowerReading = 8'h90;
  localparam logic [7:0] OffRealPowerReading = 8'h94;
  localparam logic [7:0] OffEnergyReadingLow = 8'h98;
  localparam logic [7:0] OffEnergyReadingHigh = 8'h9c;
  localparam logic [7:0] OffSwitchRunningHours = 8'ha0;
  localparam logic [7:0] OffLoadHoursReading = 8'ha4;
  // own control block
  localparam logic [7:0] OffNodeStatus = 8'hc0;
  localparam logic [7:0] OffIrqStatus = 8'hc4;
  localparam logic [7:0] OffIrqMask = 8'hc8;

  // power-reset defaults
  localparam logic [15:0] RstOverVoltageLimit = 16'd660;
  localparam logic [15:0] RstUnderVoltageLimit = 16'd0;
  localparam logic [15:0] RstUnderCurrentLimit = 16'd0;
  localparam logic [15:0] RstOverFrequencyLimit = 16'd66;
  localparam logic [15:0] RstUnderFrequencyLimit = 16'd44;
  localparam logic [15:0] RstOverTempPrewarning = 16'd0;
  localparam logic [15:0] RstHoldCurrentPeriod = 16'd18;
  localparam logic [15:0] RstLoadHoursPreset = 16'd0;
  localparam logic [15:0] RstLoadDevVoltageRef = 16'd0;
  localparam logic [15:0] RstLoadDevCurrentRef = 16'd0;
  localparam logic [15:0] RstLoadDevPercentage = 16'd10;
  localparam logic [15:0] RstOutputSubstituteMode = 16'd1;
  localparam logic [15:0] RstOutputSubstituteValue = 16'd0;
  localparam logic [15:0] RstFiringSetup = 16'd1;
  // time base held in tenths, so 0.1 reads as 1
  localparam logic [15:0] RstTimeBaseSetting = 16'd1;
  localparam logic [15:0] RstControlLevel = 16'd0;
  localparam logic [15:0] RstOnOffControlZero = 16'd0;
  localparam logic [15:0] RstOnOffControlOne = 16'd0;

  // node identifier rules
  localparam logic [7:0] NodeIdMin = 8'd1;
  localparam logic [7:0] NodeIdMax = 8'd48;
  localparam logic [7:0] IdFactory = 8'd255;
  localparam logic [7:0] CtrlIdBadLo = 8'd248;
  localparam logic [7:0] CtrlIdZero = 8'd0;

  // interrupt status bits
  localparam int IrqCfgLost = 0;
  localparam int IrqRefused = 1;
  localparam int IrqW = 2;

  typedef enum logic [1:0] {
    CfgUnconfigured = 2'b00,
    CfgCorrect = 2'b01,
    CfgWrong = 2'b10
  } cfg_state_e;

  typedef struct packed {
    logic [15:0] holdCurrent;
    logic [15:0] rmsVoltage;
    logic [15:0] lineFrequency;
    logic [15:0] rmsCurrent;
    logic [15:0] apparentPower;
    logic [15:0] realPower;
  } live_meas_s;

  typedef struct packed {
    logic [7:0] nodeId;
    logic [7:0] ctrlId;
    logic [7:0] busPosition;
    logic [7:0] attachedCtrlId;
  } node_ident_s;

endpackage : relay_node_pkg

// file: core/relay_node_regs.sv
// register bank of one switching node behind an axi4-lite slave
`timescale 1ns/1ps
// Notes on behaviour
// [RULE1] host reaches controller and nodes only through the serial field link
// [RULE2] host matches its serial settings to controller defaults
// [RULE3] host gives every controller a unique identifier before operation
// [RULE4] node traffic is served only while the node is correctly configured
// [RULE5] nodes start unconfigured; host runs automatic id assignment first
// [RULE6] holding registers return to defaults on every power reset
// [RULE7] over-voltage limit resets to 660, under-voltage limit to 0
// [RULE8] over-frequency limit resets to 66, under-frequency limit to 44
// [RULE9] over-current resets to model rating, under-current to 0
// [RULE10] hold-current period resets to 18, over-temperature pre-warning to 0
// [RULE11] load deviation percentage resets to 10, both references to 0
// [RULE12] substitute mode resets to 1, substitute value to 0
// [RULE13] firing setup 1, time base 0.1, control and on/off registers 0
// [RULE14] energy and running hours resume from values kept at power-off
// [RULE15] hold current, voltage, frequency, current and powers read live values
// [RULE16] energy is read as separate low and high registers
// [RULE17] load hours preset register resets to 0
// [RULE18] correct: node id 1..48 equals bus position, controller id matches
// [RULE19] unconfigured: node id 255 or out of range, or bad controller id
module relay_node_regs #(
  parameter logic [15:0] MaxCurrentRating = 16'd100
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [relay_node_pkg::AddrW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [relay_node_pkg::AddrW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire relay_node_pkg::live_meas_s liveMeas,
  input wire relay_node_pkg::node_ident_s nodeIdent,
  input wire logic [31:0] retainedEnergy,
  input wire logic [15:0] retainedSwitchHours,
  input wire logic [15:0] loadHoursReading,
  output logic nodeConfigured,
  output logic irq
);
  import relay_node_pkg::*;

  localparam int NHold = 19;
  localparam logic [NHold*16-1:0] HoldRst = {
    RstOnOffControlOne, RstOnOffControlZero, RstControlLevel, RstTimeBaseSetting,
    RstFiringSetup, RstOutputSubstituteValue, RstOutputSubstituteMode, // see [RULE12] [RULE13]
    RstLoadDevPercentage, RstLoadDevCurrentRef, RstLoadDevVoltageRef, // see [RULE11]
    RstLoadHoursPreset, RstHoldCurrentPeriod, RstOverTempPrewarning, // see [RULE10] [RULE17]
    RstUnderFrequencyLimit, RstOverFrequencyLimit, RstUnderCurrentLimit, // see [RULE8]
    16'd0, RstUnderVoltageLimit, RstOverVoltageLimit}; // see [RULE7]
  localparam int IdxOverCurrent = 2;

  logic [15:0] hold_q [NHold];
  logic [15:0] hold_d [NHold];
  logic awHeld_q, awHeld_d, wHeld_q, wHeld_d;
  logic [AddrW-1:0] awAddr_q, awAddr_d;
  logic [31:0] wData_q, wData_d;
  logic [3:0] wStrb_q, wStrb_d;
  logic bValid_q, bValid_d;
  logic [1:0] bResp_q, bResp_d;
  logic rValid_q, rValid_d;
  logic [1:0] rResp_q, rResp_d;
  logic [31:0] rData_q, rData_d;
  logic [IrqW-1:0] irqSts_q, irqSts_d, irqMsk_q, irqMsk_d;
  logic irq_q, irq_d;
  cfg_state_e cfg_q, cfg_d;
  logic [31:0] energy_q, energy_d;
  logic [15:0] swHours_q, swHours_d;
  logic resumed_q, resumed_d;
  logic doWrite;
  logic wrHit;
  logic [4:0] wrIdx;
  logic rdRefused, wrRefused;
  logic [31:0] rdVal;
  logic rdOk;

  // classify stored identifiers
  always_comb
  begin
    if (nodeIdent.nodeId == IdFactory || nodeIdent.nodeId < NodeIdMin ||
        nodeIdent.nodeId > NodeIdMax || nodeIdent.ctrlId == IdFactory ||
        nodeIdent.ctrlId == CtrlIdZero || nodeIdent.ctrlId >= CtrlIdBadLo)
    begin
      cfg_d = CfgUnconfigured; // see [RULE19]
    end
    else if (nodeIdent.nodeId == nodeIdent.busPosition &&
             nodeIdent.ctrlId == nodeIdent.attachedCtrlId)
    begin
      cfg_d = CfgCorrect; // see [RULE18]
    end
    else
    begin
      cfg_d = CfgWrong;
    end
  end

  // write path: address and data accepted in either order
  assign doWrite = awHeld_q && wHeld_q && !bValid_q; // see [RULE1]

  always_comb
  begin
    wrHit = 1'b0;
    wrIdx = 5'd0;
    for (int i = 0; i < NHold; i++)
    begin
      if (awAddr_q == 8'(i * 4))
      begin
        wrHit = 1'b1;
        wrIdx = 5'(i);
      end
    end
  end

  // node registers answer only for a correctly configured node
  assign wrRefused = cfg_q != CfgCorrect && awAddr_q < OffNodeStatus; // see [RULE4]

  always_comb
  begin
    awHeld_d = awHeld_q;
    wHeld_d = wHeld_q;
    awAddr_d = awAddr_q;
    wData_d = wData_q;
    wStrb_d = wStrb_q;
    bValid_d = bValid_q;
    bResp_d = bResp_q;
    irqMsk_d = irqMsk_q;
    irqSts_d = irqSts_q;
    for (int i = 0; i < NHold; i++)
    begin
      hold_d[i] = hold_q[i];
    end
    if (s_axi_awvalid && !awHeld_q)
    begin
      awHeld_d = 1'b1;
      awAddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wHeld_q)
    begin
      wHeld_d = 1'b1;
      wData_d = s_axi_wdata;
      wStrb_d = s_axi_wstrb;
    end
    if (doWrite)
    begin
      awHeld_d = 1'b0;
      wHeld_d = 1'b0;
      bValid_d = 1'b1;
      bResp_d = 2'b00;
      if (awAddr_q == OffIrqMask)
      begin
        if (wStrb_q[0])
        begin
          irqMsk_d = wData_q[IrqW-1:0];
        end
      end
      else if (awAddr_q == OffIrqStatus)
      begin
        if (wStrb_q[0])
        begin
          irqSts_d = irqSts_q & ~wData_q[IrqW-1:0];
        end
      end
      else if (wrRefused)
      begin
        bResp_d = 2'b10;
      end
      else if (wrHit)
      begin
        if (wStrb_q[0])
        begin
          hold_d[wrIdx][7:0] = wData_q[7:0];
        end
        if (wStrb_q[1])
        begin
          hold_d[wrIdx][15:8] = wData_q[15:8];
        end
      end
      else if (awAddr_q == OffNodeStatus || (awAddr_q >= OffHoldCurrentReading &&
               awAddr_q <= OffLoadHoursReading && awAddr_q[1:0] == 2'b00))
      begin
        bResp_d = 2'b00; // read-only: write ignored
      end
      else
      begin
        bResp_d = 2'b11;
      end
    end
    else if (bValid_q && s_axi_bready)
    begin
      bValid_d = 1'b0;
    end
    // events set after clear so a coinciding set wins
    if (cfg_q == CfgCorrect && cfg_d != CfgCorrect)
    begin
      irqSts_d[IrqCfgLost] = 1'b1;
    end
    if ((doWrite && wrRefused && awAddr_q != OffIrqMask && awAddr_q != OffIrqStatus) ||
        (s_axi_arvalid && !rValid_q && rdRefused))
    begin
      irqSts_d[IrqRefused] = 1'b1;
    end
  end

  // read path
  assign rdRefused = cfg_q != CfgCorrect && s_axi_araddr < OffNodeStatus; // see [RULE4]

  always_comb
  begin
    rdVal = 32'h0000_0000;
    rdOk = 1'b1;
    if (s_axi_araddr < 8'(NHold * 4) && s_axi_araddr[1:0] == 2'b00)
    begin
      rdVal = {16'h0000, hold_q[s_axi_araddr[6:2]]};
    end
    else
    begin
      case (s_axi_araddr)
        OffHoldCurrentReading: rdVal = {16'h0000, liveMeas.holdCurrent}; // see [RULE15]
        OffRmsVoltageReading: rdVal = {16'h0000, liveMeas.rmsVoltage};
        OffLineFrequencyReading: rdVal = {16'h0000, liveMeas.lineFrequency};
        OffRmsCurrentReading: rdVal = {16'h0000, liveMeas.rmsCurrent};
        OffApparentPowerReading: rdVal = {16'h0000, liveMeas.apparentPower};
        OffRealPowerReading: rdVal = {16'h0000, liveMeas.realPower};
        OffEnergyReadingLow: rdVal = {16'h0000, energy_q[15:0]}; // see [RULE16]
        OffEnergyReadingHigh: rdVal = {16'h0000, energy_q[31:16]}; // see [RULE16]
        OffSwitchRunningHours: rdVal = {16'h0000, swHours_q};
        OffLoadHoursReading: rdVal = {16'h0000, loadHoursReading};
        OffNodeStatus: rdVal = {30'h0000_0000, cfg_q};
        OffIrqStatus: rdVal = {30'h0000_0000, irqSts_q};
        OffIrqMask: rdVal = {30'h0000_0000, irqMsk_q};
        default: rdOk = 1'b0;
      endcase
    end
  end

  always_comb
  begin
    rValid_d = rValid_q;
    rResp_d = rResp_q;
    rData_d = rData_q;
    if (s_axi_arvalid && !rValid_q)
    begin
      rValid_d = 1'b1;
      rResp_d = rdRefused ? 2'b10 : (rdOk ? 2'b00 : 2'b11);
      rData_d = (rdRefused || !rdOk) ? 32'h0000_0000 : rdVal;
    end
    else if (rValid_q && s_axi_rready)
    begin
      rValid_d = 1'b0;
    end
  end

  // retained counters are latched once after reset release; the supply
  // side keeps them alive, a real part would restore from nonvolatile store
  always_comb
  begin
    resumed_d = 1'b1;
    energy_d = resumed_q ? energy_q : retainedEnergy; // see [RULE14]
    swHours_d = resumed_q ? swHours_q : retainedSwitchHours; // see [RULE14]
    irq_d = |(irqSts_d & irqMsk_d);
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NHold; i++)
      begin
        hold_q[i] <= HoldRst[i*16 +: 16]; // see [RULE6]
      end
      hold_q[IdxOverCurrent] <= MaxCurrentRating; // see [RULE9]
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      bValid_q <= 1'b0;
      bResp_q <= 2'b00;
      rValid_q <= 1'b0;
      rResp_q <= 2'b00;
      rData_q <= 32'h0000_0000;
      irqSts_q <= 2'h0;
      irqMsk_q <= 2'h0;
      irq_q <= 1'b0;
      cfg_q <= CfgUnconfigured; // see [RULE5]
      energy_q <= 32'h0000_0000;
      swHours_q <= 16'h0000;
      resumed_q <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < NHold; i++)
      begin
        hold_q[i] <= hold_d[i];
      end
      awHeld_q <= awHeld_d;
      wHeld_q <= wHeld_d;
      awAddr_q <= awAddr_d;
      wData_q <= wData_d;
      wStrb_q <= wStrb_d;
      bValid_q <= bValid_d;
      bResp_q <= bResp_d;
      rValid_q <= rValid_d;
      rResp_q <= rResp_d;
      rData_q <= rData_d;
      irqSts_q <= irqSts_d;
      irqMsk_q <= irqMsk_d;
      irq_q <= irq_d;
      cfg_q <= cfg_d;
      energy_q <= energy_d;
      swHours_q <= swHours_d;
      resumed_q <= resumed_d;
    end
  end

  assign s_axi_awready = !awHeld_q;
  assign s_axi_wready = !wHeld_q;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;
  assign s_axi_arready = !rValid_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rresp = rResp_q;
  assign s_axi_rdata = rData_q;
  assign nodeConfigured = cfg_q == CfgCorrect;
  assign irq = irq_q;

  AST_OVLIM_RESET: assert property (@(posedge sys_clk) $rose(rst_n) |->
    hold_q[0] == 16'd660 && hold_q[1] == 16'd0) else $error("voltage limits bad after reset"); // see [RULE7]
  AST_FREQ_RESET: assert property (@(posedge sys_clk) $rose(rst_n) |->
    hold_q[4] == 16'd66 && hold_q[5] == 16'd44) else $error("frequency limits bad after reset"); // see [RULE8]
  AST_CUR_RESET: assert property (@(posedge sys_clk) $rose(rst_n) |->
    hold_q[2] == MaxCurrentRating && hold_q[3] == 16'd0) else $error("current limits bad"); // see [RULE9]
  AST_HOLD_RESET: assert property (@(posedge sys_clk) $rose(rst_n) |->
    hold_q[7] == 16'd18 && hold_q[6] == 16'd0) else $error("hold period bad after reset"); // see [RULE10]
  AST_LDEV_RESET: assert property (@(posedge sys_clk) $rose(rst_n) |->
    hold_q[11] == 16'd10 && hold_q[9] == 16'd0 && hold_q[10] == 16'd0)
    else $error("load deviation defaults bad"); // see [RULE11]
  AST_SUBST_RESET: assert property (@(posedge sys_clk) $rose(rst_n) |->
    hold_q[12] == 16'd1 && hold_q[13] == 16'd0) else $error("substitute defaults bad"); // see [RULE12]
  AST_FIRE_RESET: assert property (@(posedge sys_clk) $rose(rst_n) |->
    hold_q[14] == 16'd1 && hold_q[15] == 16'd1 && hold_q[16] == 16'd0 && hold_q[17] == 16'd0 &&
    hold_q[18] == 16'd0) else $error("firing defaults bad"); // see [RULE13]
  AST_PRESET_RESET: assert property (@(posedge sys_clk) $rose(rst_n) |->
    hold_q[8] == 16'd0) else $error("load hours preset bad"); // see [RULE17]
  AST_REFUSE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_axi_arvalid && s_axi_arready && cfg_q != CfgCorrect && s_axi_araddr < 8'hc0 |=>
    s_axi_rvalid && s_axi_rresp == 2'b10) else $error("unconfigured node served"); // see [RULE4]
  AST_UNCFG: assert property (@(posedge sys_clk) disable iff (!rst_n)
    nodeIdent.nodeId == 8'd255 |=> cfg_q == CfgUnconfigured) else $error("factory id not unconfigured"); // see [RULE19]
  AST_CORRECT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cfg_q == CfgCorrect |-> $past(nodeIdent.nodeId) == $past(nodeIdent.busPosition))
    else $error("correct state with id mismatch"); // see [RULE18]
  AST_ENERGY: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h9c && cfg_q == CfgCorrect |=>
    s_axi_rdata[15:0] == $past(energy_q[31:16])) else $error("energy high word wrong"); // see [RULE16]

endmodule : relay_node_regs

// file: tb/node_env_model.sv
// node side model: identity words, live measurements and retained counters
`timescale 1ns/1ps
module node_env_model #(
  parameter logic [31:0] RetEnergy = 32'h0001_2345,
  parameter logic [15:0] RetHours = 16'h0777,
  parameter logic [15:0] LoadHours = 16'h0042
) (
  input wire logic [3:0] identSel,
  input wire logic [15:0] measBase,
  output relay_node_pkg::live_meas_s liveMeas,
  output relay_node_pkg::node_ident_s nodeIdent,
  output logic [31:0] retainedEnergy,
  output logic [15:0] retainedSwitchHours,
  output logic [15:0] loadHoursReading
);
  import relay_node_pkg::*;
  // node id, stored controller id, bus position, attached controller id
  // controller id 07 is unique to the attached controller
  localparam logic [31:0] IdentTable [12] = '{32'hffff_0307, 32'h0507_0507, 32'h3007_3007,
    32'h0107_0107, 32'h0507_0607, 32'h3107_3107, 32'h0500_0500, 32'h05f8_05f8,
    32'h05fe_05fe, 32'h0507_0509, 32'h0007_0007, 32'h05ff_05ff};
  always_comb
  begin
    nodeIdent = IdentTable[identSel];
    // each field distinct so a swapped register decode shows up
    liveMeas = '{measBase, measBase + 16'h0001, measBase + 16'h0002,
      measBase + 16'h0003, measBase + 16'h0004, measBase + 16'h0005};
  end
  assign retainedEnergy = RetEnergy;
  assign retainedSwitchHours = RetHours;
  assign loadHoursReading = LoadHours;
endmodule : node_env_model

// file: tb/tb_relay_node_power_up_register_defaults.sv
// self-checking bench for the switching node register bank
`timescale 1ns/1ps
module tb_relay_node_power_up_register_defaults;
  import relay_node_pkg::*;
  localparam logic [15:0] Rating = 16'h00fa;
  localparam logic [31:0] RetEnergy = 32'h0001_2345;
  localparam logic [15:0] RetHours = 16'h0777;
  localparam logic [15:0] LoadHours = 16'h0042;
  localparam int Ceiling = 20000;
  localparam logic [15:0] Dflt [19] = '{16'h0294, 16'h0000, Rating, 16'h0000, 16'h0042,
    16'h002c, 16'h0000, 16'h0012, 16'h0000, 16'h0000, 16'h0000, 16'h000a, 16'h0001,
    16'h0000, 16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [1:0] IdentExp [12] = '{2'd0, 2'd1, 2'd1, 2'd1, 2'd2, 2'd0, 2'd0, 2'd0,
    2'd0, 2'd2, 2'd0, 2'd0};
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  live_meas_s liveMeas;
  node_ident_s nodeIdent;
  logic [31:0] retainedEnergy;
  logic [15:0] retainedSwitchHours;
  logic [15:0] loadHoursReading;
  logic nodeConfigured;
  logic irq;
  logic [3:0] identSel = 4'h0;
  logic [15:0] measBase = 16'h0100;
  logic [31:0] d;
  logic [1:0] r;
  int fails = 0;
  int samplesChecked = 0;
  int cycles = 0;

  always #2.5 sys_clk = ~sys_clk;

  relay_node_regs #(.MaxCurrentRating(Rating)) relay_node_regs_inst (
    .sys_clk(sys_clk), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .liveMeas(liveMeas),
    .nodeIdent(nodeIdent), .retainedEnergy(retainedEnergy),
    .retainedSwitchHours(retainedSwitchHours), .loadHoursReading(loadHoursReading),
    .nodeConfigured(nodeConfigured), .irq(irq));

  node_env_model #(.RetEnergy(RetEnergy), .RetHours(RetHours), .LoadHours(LoadHours))
    node_env_model_inst (.identSel(identSel), .measBase(measBase), .liveMeas(liveMeas),
    .nodeIdent(nodeIdent), .retainedEnergy(retainedEnergy),
    .retainedSwitchHours(retainedSwitchHours), .loadHoursReading(loadHoursReading));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic results;
    if (fails == 0 && samplesChecked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results

  // both channels offered together, each dropped once taken
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] wd, input logic [3:0] s,
      output logic [1:0] resp);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= wd;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
      begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : axiWrite

  task automatic axiRead(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] resp);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
      begin
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : axiRead

  task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] rd;
    logic [1:0] rr;
    axiRead(a, rd, rr);
    check(rd, e);
    check({30'h0, rr}, {30'h0, er});
  endtask : rdChk

  task automatic wrChk(input logic [7:0] a, input logic [31:0] wd, input logic [3:0] s,
      input logic [1:0] er);
    logic [1:0] rr;
    axiWrite(a, wd, s, rr);
    check({30'h0, rr}, {30'h0, er});
  endtask : wrChk

  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == Ceiling)
    begin
      fails++;
      results();
    end
  end

  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    // factory identity: node data refused, control block still open
    rdChk(8'hc0, 32'h0, 2'b00);
    check({31'h0, nodeConfigured}, 32'h0);
    rdChk(8'h00, 32'h0, 2'b10);
    rdChk(8'h84, 32'h0, 2'b10);
    wrChk(8'h00, 32'h0000_0100, 4'hf, 2'b10);
    axiRead(8'hc4, d, r);
    check(d & 32'h2, 32'h2);
    rdChk(8'hc8, 32'h0, 2'b00);
    check({31'h0, irq}, 32'h0);
    wrChk(8'hc8, 32'h2, 4'hf, 2'b00);
    repeat (2) @(posedge sys_clk);
    check({31'h0, irq}, 32'h1);
    wrChk(8'hc4, 32'h3, 4'hf, 2'b00);
    repeat (2) @(posedge sys_clk);
    check({31'h0, irq}, 32'h0);
    axiRead(8'hc4, d, r);
    check(d & 32'h2, 32'h0);
    // classification over boundary identities
    for (int i = 0; i < 12; i++)
    begin
      identSel <= 4'(i);
      repeat (3) @(posedge sys_clk);
      rdChk(8'hc0, {30'h0, IdentExp[i]}, 2'b00);
      check({31'h0, nodeConfigured}, {31'h0, IdentExp[i] == 2'd1});
    end
    identSel <= 4'h1;
    repeat (3) @(posedge sys_clk);
    // the correct-to-wrong step in the sweep must have flagged a lost configuration
    axiRead(8'hc4, d, r);
    check(d & 32'h1, 32'h1);
    // the refused write above must not have landed
    for (int i = 0; i < 19; i++)
      rdChk(8'(i * 4), {16'h0, Dflt[i]}, 2'b00);
    for (int i = 0; i < 19; i++)
      wrChk(8'(i * 4), 32'habcd_1230 + i, 4'hf, 2'b00);
    for (int i = 0; i < 19; i++)
      rdChk(8'(i * 4), 32'h0000_1230 + i, 2'b00);
    wrChk(8'h00, 32'h0000_beef, 4'h1, 2'b00);
    rdChk(8'h00, 32'h0000_12ef, 2'b00);
    // second power reset in mid-run
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    for (int i = 0; i < 19; i++)
      rdChk(8'(i * 4), {16'h0, Dflt[i]}, 2'b00);
    rdChk(8'hc4, 32'h0, 2'b00);
    // live readings follow the inputs, retained counters survive reset
    for (int b = 0; b < 2; b++)
    begin
      measBase <= (b == 0) ? 16'h0100 : 16'h0a50;
      @(posedge sys_clk);
      for (int k = 0; k < 6; k++)
        rdChk(8'(8'h80 + k * 4), {16'h0, measBase + 16'(k)}, 2'b00);
    end
    rdChk(8'h98, {16'h0, RetEnergy[15:0]}, 2'b00);
    rdChk(8'h9c, {16'h0, RetEnergy[31:16]}, 2'b00);
    rdChk(8'ha0, {16'h0, RetHours}, 2'b00);
    rdChk(8'ha4, {16'h0, LoadHours}, 2'b00);
    wrChk(8'h84, 32'h0000_1111, 4'hf, 2'b00);
    rdChk(8'h84, 32'h0000_0a51, 2'b00);
    axiRead(8'h4c, d, r);
    check({30'h0, r}, 32'h3);
    wrChk(8'hfc, 32'h0000_0001, 4'hf, 2'b11);
    results();
  end
endmodule : tb_relay_node_power_up_register_defaults
